// ### src/urx_pkg.sv
package urx_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE_RX   = 8'h00;
   localparam logic [7:0] OFS_MODE_PAIR = 8'h04;
   localparam logic [7:0] OFS_SETUP     = 8'h08;
   localparam logic [7:0] OFS_DATA      = 8'h0C;
   localparam logic [7:0] OFS_STATUS    = 8'h10;
   localparam logic [7:0] OFS_FLAG_CLR  = 8'h14;
   localparam logic [7:0] OFS_START     = 8'h18;
   localparam logic [7:0] OFS_STOP      = 8'h1C;
   localparam logic [7:0] OFS_ENABLED   = 8'h20;
   localparam logic [7:0] OFS_PRESCALE  = 8'h24;
   // Mode register fields
   localparam int MODE_CKS_BIT  = 15;
   localparam int MODE_INV_BIT  = 6;
   localparam int MODE_IRQ_BIT  = 0;
   // Setup register fields
   localparam int SETUP_RXE_BIT = 14;
   localparam int SETUP_EOC_BIT = 10;
   localparam int SETUP_PTC_LSB = 8;
   localparam int SETUP_DIR_BIT = 7;
   localparam int SETUP_DLS_BIT = 0;
   // Status register fields
   localparam int STAT_BFF_BIT  = 5;
   localparam int STAT_FEF_BIT  = 2;
   localparam int STAT_PEF_BIT  = 1;
   localparam int STAT_OVF_BIT  = 0;
   // Start and stop register channel bit
   localparam int CHAN_RX_BIT   = 1;
   // Data register divider field
   localparam int DATA_DIV_LSB  = 9;
   // Reset values
   localparam logic [15:0] MODE_RESET  = 16'h0020;
   localparam logic [15:0] SETUP_RESET = 16'h0087;
   localparam logic [15:0] DIV_RESET   = 16'h0000;
   localparam logic [7:0]  PRS_RESET   = 8'h00;
   // Parity modes
   localparam logic [1:0] PAR_NONE = 2'h0;
   localparam logic [1:0] PAR_ZERO = 2'h1;
   localparam logic [1:0] PAR_EVEN = 2'h2;
   localparam logic [1:0] PAR_ODD  = 2'h3;
   // Timing
   localparam int CLK_PERIOD_PS    = 4000;
   localparam int RXE_SETTLE_CLKS  = 4;
   localparam int STOP_MASK        = 3;
   localparam logic [3:0] PRS_MAX  = 4'hF;
   typedef enum logic [1:0] {
      URX_IDLE  = 2'b00,
      URX_START = 2'b01,
      URX_DATA  = 2'b11,
      URX_STOP  = 2'b10
   } urx_state_t;
endpackage : urx_pkg

// ### src/urx_tick_if.sv
`timescale 1ns/1ps
interface urx_tick_if;
   logic       cks;
   logic [7:0] prs;
   logic       tick;
   modport src (input cks, input prs, output tick);
   modport dst (output cks, output prs, input tick);
endinterface : urx_tick_if

// ### src/urx_prescaler.sv
`timescale 1ns/1ps
// Divides the system clock by 2^m and picks output zero or one
module urx_prescaler (
   // Clock and reset
   input  wire logic mclk_i,
   input  wire logic reset_i,
   // Tick carrier
   urx_tick_if.src   tk
);
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [3:0]  m_sel;
   logic [15:0] mask;

   always_comb begin
      next_cnt = cnt + 16'h0001;
      m_sel    = tk.cks ? tk.prs[7:4] : tk.prs[3:0];
      mask     = 16'(({16'h0000, 16'h0001} << m_sel) - 32'h1);
      tk.tick  = ((cnt & mask) == mask);
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cnt <= 16'h0000;
      end else begin
         cnt <= next_cnt;
      end
   end
endmodule : urx_prescaler

// ### src/urx_channel.sv
`timescale 1ns/1ps
module urx_channel (
   // Clock and reset
   input  wire logic        mclk_i,
   input  wire logic        reset_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Serial line
   input  wire logic        serial_rx_pin_i,
   // Interrupts
   output logic             rx_done_irq_o,
   output logic             rx_error_irq_o
);
   urx_tick_if tk ();

   // Register state
   logic [15:0] mode_rx, mode_pair, setup, div_reg;
   logic [7:0]  prs, rx_data;
   logic        enabled, bff, fef, pef, ovf;
   logic [15:0] next_mode_rx, next_mode_pair, next_setup, next_div_reg;
   logic [7:0]  next_prs, next_rx_data;
   logic        next_enabled, next_bff, next_fef, next_pef, next_ovf;
   logic [31:0] next_prdata;
   // Receiver state
   urx_pkg::urx_state_t state, next_state;
   logic [6:0]  bcnt, next_bcnt;
   logic [3:0]  nbits, next_nbits;
   logic [7:0]  shreg, next_shreg;
   logic        par_bit, next_par_bit;
   logic        pend_pef, next_pend_pef;
   logic        line_q, next_line_q;
   logic        done_p, next_done_p, err_p, next_err_p;
   // Decoded configuration
   logic        rx_level, wr_acc, rd_acc, eight, lsb_first, half_tick;
   logic [1:0]  ptc;
   logic [6:0]  divk;
   logic [3:0]  data_bits, frame_bits;
   logic        frame_end, set_fef, set_pef, set_ovf;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   urx_prescaler u_prs (
      .mclk_i  (mclk_i),
      .reset_i (reset_i),
      .tk      (tk.src)
   );

   assign tk.cks    = mode_rx[urx_pkg::MODE_CKS_BIT];
   assign tk.prs    = prs;
   assign pready_o  = 1'b1;
   assign pslverr_o = 1'b0;
   assign rx_done_irq_o  = done_p;
   assign rx_error_irq_o = err_p;

   always_comb begin
      wr_acc    = psel_i & penable_i & pwrite_i;
      rd_acc    = psel_i & penable_i & ~pwrite_i;
      rx_level  = serial_rx_pin_i ^ mode_rx[urx_pkg::MODE_INV_BIT];
      eight     = setup[urx_pkg::SETUP_DLS_BIT];
      lsb_first = setup[urx_pkg::SETUP_DIR_BIT];
      ptc       = setup[urx_pkg::SETUP_PTC_LSB +: 2];
      divk      = div_reg[urx_pkg::DATA_DIV_LSB +: 7];
      data_bits = eight ? 4'h8 : 4'h7;
      frame_bits = data_bits + ((ptc != urx_pkg::PAR_NONE) ? 4'h1 : 4'h0);
      // Half a bit lasts divk+1 operation clocks
      half_tick = tk.tick & (bcnt == divk);
   end

   // Receiver
   always_comb begin
      next_state   = state;
      next_bcnt    = bcnt;
      next_nbits   = nbits;
      next_shreg   = shreg;
      next_par_bit = par_bit;
      next_line_q  = rx_level;
      frame_end    = 1'b0;
      set_fef      = 1'b0;
      set_pef      = 1'b0;
      if (tk.tick) begin
         next_bcnt = half_tick ? 7'h00 : 7'(bcnt + 7'h01);
      end
      if (!enabled || !setup[urx_pkg::SETUP_RXE_BIT]) begin
         next_state = urx_pkg::URX_IDLE;
         next_bcnt  = 7'h00;
      end else begin
         unique case (state)
            urx_pkg::URX_IDLE: begin
               next_bcnt = 7'h00;
               if (line_q && !rx_level) begin
                  next_state = urx_pkg::URX_START;
                  next_nbits = 4'h0;
               end
            end
            urx_pkg::URX_START: begin
               // Start level re-checked at its centre; a short glitch falls back to idle
               if (half_tick) begin
                  next_state = rx_level ? urx_pkg::URX_IDLE : urx_pkg::URX_DATA;
                  next_par_bit = 1'b0;
               end
            end
            urx_pkg::URX_DATA: begin
               // Two half bits make a full bit; latch on odd half
               if (half_tick) begin
                  next_par_bit = ~par_bit;
                  if (par_bit) begin
                     next_par_bit = 1'b0;
                     next_nbits = 4'(nbits + 4'h1);
                     if (nbits < data_bits) begin
                        if (lsb_first) begin
                           next_shreg = eight ? {rx_level, shreg[7:1]} : {1'b0, rx_level, shreg[6:1]};
                        end else begin
                           next_shreg = eight ? {shreg[6:0], rx_level} : {1'b0, shreg[5:0], rx_level};
                        end
                     end else begin
                        unique case (ptc)
                           urx_pkg::PAR_EVEN: set_pef = rx_level ^ (^shreg);
                           urx_pkg::PAR_ODD:  set_pef = ~(rx_level ^ (^shreg));
                           default:           set_pef = 1'b0;
                        endcase
                     end
                     if (4'(nbits + 4'h1) == frame_bits) begin
                        next_state = urx_pkg::URX_STOP;
                     end
                  end
               end
            end
            urx_pkg::URX_STOP: begin
               if (half_tick) begin
                  next_par_bit = ~par_bit;
                  if (par_bit) begin
                     frame_end  = 1'b1;
                     set_fef    = ~rx_level;
                     next_state = urx_pkg::URX_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Register file
   always_comb begin
      next_mode_rx   = mode_rx;
      next_mode_pair = mode_pair;
      next_setup     = setup;
      next_div_reg   = div_reg;
      next_prs       = prs;
      next_enabled   = enabled;
      next_rx_data   = rx_data;
      next_bff       = bff;
      next_fef       = fef;
      next_pef       = pef;
      next_ovf       = ovf;
      next_prdata    = 32'h0000_0000;
      set_ovf        = frame_end & bff & ~(rd_acc & hit(paddr_i, urx_pkg::OFS_DATA));
      if (wr_acc) begin
         if (hit(paddr_i, urx_pkg::OFS_MODE_RX))   next_mode_rx   = pwdata_i[15:0];
         if (hit(paddr_i, urx_pkg::OFS_MODE_PAIR)) next_mode_pair = pwdata_i[15:0];
         if (hit(paddr_i, urx_pkg::OFS_SETUP))     next_setup     = pwdata_i[15:0];
         if (hit(paddr_i, urx_pkg::OFS_DATA))      next_div_reg   = {pwdata_i[15:9], 9'h000};
         if (hit(paddr_i, urx_pkg::OFS_PRESCALE))  next_prs       = pwdata_i[7:0];
         if (hit(paddr_i, urx_pkg::OFS_START) && pwdata_i[urx_pkg::CHAN_RX_BIT]) next_enabled = 1'b1;
         if (hit(paddr_i, urx_pkg::OFS_STOP) && pwdata_i[urx_pkg::CHAN_RX_BIT])  next_enabled = 1'b0;
         if (hit(paddr_i, urx_pkg::OFS_FLAG_CLR)) begin
            if (pwdata_i[urx_pkg::STAT_FEF_BIT]) next_fef = 1'b0;
            if (pwdata_i[urx_pkg::STAT_PEF_BIT]) next_pef = 1'b0;
            if (pwdata_i[urx_pkg::STAT_OVF_BIT]) next_ovf = 1'b0;
         end
      end
      if (rd_acc && hit(paddr_i, urx_pkg::OFS_DATA)) next_bff = 1'b0;
      if (frame_end) begin
         next_rx_data = shreg;
         next_bff     = 1'b1;
      end
      if (set_fef) next_fef = 1'b1;
      // Parity error seen mid-frame is reported when the frame ends; set beats clear
      if (pend_pef && frame_end) next_pef = 1'b1;
      if (set_ovf) next_ovf = 1'b1;
      if (psel_i && !pwrite_i) begin
         if (hit(paddr_i, urx_pkg::OFS_MODE_RX))   next_prdata = {16'h0000, mode_rx};
         if (hit(paddr_i, urx_pkg::OFS_MODE_PAIR)) next_prdata = {16'h0000, mode_pair};
         if (hit(paddr_i, urx_pkg::OFS_SETUP))     next_prdata = {16'h0000, setup};
         if (hit(paddr_i, urx_pkg::OFS_DATA))      next_prdata = {16'h0000, div_reg[15:9], 1'b0, rx_data};
         if (hit(paddr_i, urx_pkg::OFS_PRESCALE))  next_prdata = {24'h000000, prs};
         if (hit(paddr_i, urx_pkg::OFS_ENABLED))   next_prdata = {30'h0, enabled, 1'b0};
         if (hit(paddr_i, urx_pkg::OFS_STATUS))
            next_prdata = {26'h0, bff, 2'b00, fef, pef, ovf};
      end
   end

   // Pending parity error held until the frame ends
   always_comb begin
      next_pend_pef = pend_pef;
      if (state == urx_pkg::URX_IDLE) next_pend_pef = 1'b0;
      if (set_pef) next_pend_pef = 1'b1;
      next_done_p = frame_end;
      next_err_p  = (set_fef | pend_pef | set_ovf) & frame_end
                    & setup[urx_pkg::SETUP_EOC_BIT];
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         mode_rx   <= urx_pkg::MODE_RESET;
         mode_pair <= urx_pkg::MODE_RESET;
         setup     <= urx_pkg::SETUP_RESET;
         div_reg   <= urx_pkg::DIV_RESET;
         prs       <= urx_pkg::PRS_RESET;
         enabled   <= 1'b0;
         rx_data   <= 8'h00;
         bff       <= 1'b0;
         fef       <= 1'b0;
         pef       <= 1'b0;
         ovf       <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         state     <= urx_pkg::URX_IDLE;
         bcnt      <= 7'h00;
         nbits     <= 4'h0;
         shreg     <= 8'h00;
         par_bit   <= 1'b0;
         line_q    <= 1'b1;
         done_p    <= 1'b0;
         err_p     <= 1'b0;
         pend_pef  <= 1'b0;
      end else begin
         mode_rx   <= next_mode_rx;
         mode_pair <= next_mode_pair;
         setup     <= next_setup;
         div_reg   <= next_div_reg;
         prs       <= next_prs;
         enabled   <= next_enabled;
         rx_data   <= next_rx_data;
         bff       <= next_bff;
         fef       <= next_fef;
         pef       <= next_pef;
         ovf       <= next_ovf;
         prdata_o  <= next_prdata;
         state     <= next_state;
         bcnt      <= next_bcnt;
         nbits     <= next_nbits;
         shreg     <= next_shreg;
         par_bit   <= next_par_bit;
         line_q    <= next_line_q;
         done_p    <= next_done_p;
         err_p     <= next_err_p;
         pend_pef  <= next_pend_pef;
      end
   end
endmodule : urx_channel

// ### bench/urx_channel_properties.sv
`timescale 1ns/1ps
module urx_channel_properties (
   // Clock and reset
   input wire logic        mclk_i,
   input wire logic        reset_i,
   // APB
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   // Interrupts
   input wire logic        rx_done_irq_o,
   input wire logic        rx_error_irq_o
);
   logic       rd, wr, en, eie, bclr, next_en, next_eie, next_bclr;
   logic [2:0] clr, next_clr;
   assign rd = psel_i & penable_i & pready_o & !pwrite_i;
   assign wr = psel_i & penable_i & pready_o & pwrite_i;
   // Mirrors of software actions; the read and flag-clear marks are dropped once a new frame lands
   always_comb begin
      next_en   = en;
      next_eie  = eie;
      next_bclr = bclr & !rx_done_irq_o;
      next_clr  = rx_done_irq_o ? 3'h0 : clr;
      if (wr && paddr_i == urx_pkg::OFS_START && pwdata_i[1]) next_en = 1'h1;
      if (wr && paddr_i == urx_pkg::OFS_STOP && pwdata_i[1]) next_en = 1'h0;
      if (wr && paddr_i == urx_pkg::OFS_SETUP) next_eie = pwdata_i[10];
      if (rd && paddr_i == urx_pkg::OFS_DATA) next_bclr = 1'h1;
      if (wr && paddr_i == urx_pkg::OFS_FLAG_CLR) next_clr = clr | pwdata_i[2:0];
   end
   always_ff @(posedge mclk_i) begin
      {en, eie, bclr, clr} <= reset_i ? 6'h0 : {next_en, next_eie, next_bclr, next_clr};
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   property p_err_done; rx_error_irq_o |-> rx_done_irq_o; endproperty
   a_err_done: assert property (p_err_done) else $error("error irq alone");
   property p_done_pulse; rx_done_irq_o |=> !rx_done_irq_o; endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("done irq too long");
   property p_spacing; $rose(rx_done_irq_o) |=> !rx_done_irq_o [*8]; endproperty
   a_spacing: assert property (p_spacing) else $error("frames too close");
   property p_err_mask; rx_error_irq_o |-> eie; endproperty
   a_err_mask: assert property (p_err_mask) else $error("error irq masked");
   property p_enabled; rd && paddr_i == urx_pkg::OFS_ENABLED |-> prdata_o[1] == en; endproperty
   a_enabled: assert property (p_enabled) else $error("enable status wrong");
   property p_halt; !en && !$past(en) |-> !rx_done_irq_o; endproperty
   a_halt: assert property (p_halt) else $error("stopped channel received");
   property p_bff; rd && paddr_i == urx_pkg::OFS_STATUS && bclr |-> !prdata_o[5]; endproperty
   a_bff: assert property (p_bff) else $error("buffer full after read");
   property p_flags; rd && paddr_i == urx_pkg::OFS_STATUS |-> (prdata_o[2:0] & clr) == 3'h0; endproperty
   a_flags: assert property (p_flags) else $error("flag not cleared");
endmodule : urx_channel_properties
bind urx_channel urx_channel_properties u_urx_channel_properties (.mclk_i, .reset_i, .psel_i, .penable_i,
   .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .rx_done_irq_o, .rx_error_irq_o);

// ### bench/urx_tx_model.sv
`timescale 1ns/1ps
// Remote sender; holds the idle level between frames
module urx_tx_model (
   // Clock and polarity
   input  wire logic mclk_i,
   input  wire logic inv_i,
   // Serial line
   output logic      line_o
);
   logic busy = 1'h0;
   initial line_o = 1'h1;
   always @(posedge mclk_i) if (!busy) line_o <= ~inv_i;
   task automatic put(input logic b, input int bt);
      line_o <= b ^ inv_i;
      repeat (bt) @(posedge mclk_i);
   endtask : put
   task automatic send(input logic [7:0] d, input int nb, input logic [1:0] par, input logic lsb, input int bt,
                       input logic bp, input logic bs);
      logic p;
      p = (nb == 7 ? ^d[6:0] : ^d) ^ (par == urx_pkg::PAR_ODD) ^ bp;
      busy = 1'h1;
      @(posedge mclk_i);
      put(1'h0, bt);
      for (int i = 0; i < nb; i++) put(lsb ? d[i] : d[nb-1-i], bt);
      if (par != urx_pkg::PAR_NONE) put(par == urx_pkg::PAR_ZERO ? bp : p, bt);
      put(!bs, bt);
      busy = 1'h0;
   endtask : send
endmodule : urx_tx_model

// ### bench/test_uart_receive_channel.sv
`timescale 1ns/1ps
module test_uart_receive_channel;
   // Clock, reset and bus
   logic        mclk_i    = 1'h0;
   logic        reset_i   = 1'h1;
   logic        psel_i    = 1'h0;
   logic        penable_i = 1'h0;
   logic        pwrite_i  = 1'h0;
   logic [7:0]  paddr_i   = 8'h00;
   logic [31:0] pwdata_i  = 32'h0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   // Line, interrupts and frame settings
   logic        serial_rx_pin_i;
   logic        rx_done_irq_o;
   logic        rx_error_irq_o;
   logic        inv = 1'h0;
   logic        lsb;
   logic [1:0]  par;
   int          nb;
   int          bt;
   int          fail_count = 0;
   int          n_tests    = 0;
   always #2 mclk_i = ~mclk_i;
   urx_channel u_urx_channel (.mclk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
      .pready_o, .pslverr_o, .serial_rx_pin_i, .rx_done_irq_o, .rx_error_irq_o);
   urx_tx_model u_urx_tx_model (.mclk_i, .inv_i(inv), .line_o(serial_rx_pin_i));
   task automatic final_report;
      if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge mclk_i);
      psel_i    <= 1'h1;
      penable_i <= 1'h0;
      pwrite_i  <= w;
      paddr_i   <= a;
      pwdata_i  <= d;
      @(posedge mclk_i);
      penable_i <= 1'h1;
      do @(posedge mclk_i); while (pready_o !== 1'h1);
      r = prdata_o;
      psel_i    <= 1'h0;
      penable_i <= 1'h0;
   endtask : apb
   task automatic wait_done(output logic got, output logic err);
      got = 1'h0;
      err = 1'h0;
      for (int i = 0; i < 4000 && !got; i++) begin
         @(negedge mclk_i);
         if (rx_done_irq_o === 1'h1) begin
            got = 1'h1;
            err = rx_error_irq_o;
         end
      end
   endtask : wait_done
   task automatic t_reset;
      logic [31:0] r;
      apb(1'h1, 8'h28, 32'hFFFFFFFF, r);
      apb(1'h0, urx_pkg::OFS_MODE_RX, 32'h0, r);
      chk("mode reset", r, 32'(urx_pkg::MODE_RESET));
      apb(1'h0, urx_pkg::OFS_SETUP, 32'h0, r);
      chk("setup reset", r, 32'(urx_pkg::SETUP_RESET));
      apb(1'h0, 8'h28, 32'h0, r);
      chk("unmapped", r, 32'h0);
      chk("slave error", pslverr_o, 32'h0);
   endtask : t_reset
   task automatic cfg(input logic ck, input logic iv, input logic [3:0] m, input logic [6:0] dv, input logic eie,
                      input logic [1:0] p, input logic l, input logic dl);
      logic [31:0] r;
      logic [31:0] v;
      apb(1'h1, urx_pkg::OFS_STOP, 32'(urx_pkg::STOP_MASK), r);
      inv <= iv;
      v = 32'(urx_pkg::MODE_RESET);
      v[15] = ck;
      v[6] = iv;
      apb(1'h1, urx_pkg::OFS_MODE_RX, v, r);
      apb(1'h1, urx_pkg::OFS_MODE_PAIR, v, r);
      apb(1'h0, urx_pkg::OFS_MODE_PAIR, 32'h0, r);
      chk("pair mode", r, v);
      // Only the selected prescaler field carries m, so a wrong select shows as a wrong rate
      apb(1'h1, urx_pkg::OFS_PRESCALE, {24'h0, ck ? {m, 4'h0} : {4'h0, m}}, r);
      apb(1'h1, urx_pkg::OFS_DATA, {16'h0, dv, 9'h0}, r);
      v = {17'h0, 1'h1, 3'h0, eie, p, l, 6'h3, dl};
      apb(1'h1, urx_pkg::OFS_SETUP, v, r);
      repeat (urx_pkg::RXE_SETTLE_CLKS) @(posedge mclk_i);
      apb(1'h1, urx_pkg::OFS_START, 32'h2, r);
      apb(1'h0, urx_pkg::OFS_ENABLED, 32'h0, r);
      chk("enabled", r[1], 1'h1);
      nb = dl ? 8 : 7;
      par = p;
      lsb = l;
      bt = 2 * (dv + 1) * (1 << m);
   endtask : cfg
   task automatic rx(input logic [7:0] d, input logic bp, input logic bs, input int nf, input logic [2:0] st,
                     input logic ee);
      logic [31:0] r;
      logic got, err;
      for (int k = 0; k < nf; k++) begin
         fork
            u_urx_tx_model.send(k ? ~d : d, nb, par, lsb, bt, bp, bs);
            wait_done(got, err);
         join
         chk("done", got, 1'h1);
      end
      chk("error irq", err, ee);
      apb(1'h0, urx_pkg::OFS_DATA, 32'h0, r);
      chk("data", r[7:0], (nf > 1 ? ~d : d) & (nb == 8 ? 8'hFF : 8'h7F));
      apb(1'h0, urx_pkg::OFS_STATUS, 32'h0, r);
      chk("status", r[5:0], {3'h0, st});
      apb(1'h1, urx_pkg::OFS_FLAG_CLR, r, r);
      apb(1'h0, urx_pkg::OFS_STATUS, 32'h0, r);
      chk("cleared", r[5:0], 6'h0);
   endtask : rx
   task automatic t_stop;
      logic [31:0] r;
      logic got, err;
      apb(1'h1, urx_pkg::OFS_STOP, 32'h2, r);
      apb(1'h0, urx_pkg::OFS_ENABLED, 32'h0, r);
      chk("stopped", r[1], 1'h0);
      fork
         u_urx_tx_model.send(8'hE7, nb, par, lsb, bt, 1'h0, 1'h0);
         wait_done(got, err);
      join
      chk("done while stopped", got, 1'h0);
   endtask : t_stop
   initial begin
      #200000;
      fail_count++;
      final_report;
   end
   initial begin
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'h0;
      t_reset;
      // Every parity mode, both orders, lengths, polarities and clock selects
      for (int i = 0; i < 8; i++) begin
         cfg(i[1], i[2], 4'(i[2]), 7'(2 + i), 1'h0, 2'(i), i[0] ^ i[1], i[0]);
         rx(8'h4B + 8'(i * 37), par == urx_pkg::PAR_ZERO, 1'h0, 1, 3'h0, 1'h0);
      end
      cfg(1'h0, 1'h0, 4'h0, 7'h2, 1'h1, urx_pkg::PAR_EVEN, 1'h1, 1'h1);
      rx(8'hC3, 1'h1, 1'h0, 1, 3'h2, 1'h1);
      rx(8'h3C, 1'h0, 1'h1, 1, 3'h4, 1'h1);
      t_stop;
      cfg(1'h0, 1'h1, 4'h0, 7'h3, 1'h1, urx_pkg::PAR_NONE, 1'h0, 1'h1);
      rx(8'h96, 1'h0, 1'h0, 2, 3'h1, 1'h1);
      cfg(1'h1, 1'h0, 4'h2, 7'h2, 1'h0, urx_pkg::PAR_ODD, 1'h1, 1'h1);
      rx(8'h5A, 1'h1, 1'h0, 1, 3'h2, 1'h0);
      final_report;
   end
endmodule : test_uart_receive_channel
